/* File: core/ldio_top.sv */
// host i/o decoder, configuration port and interrupt routing
module ldio_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic strap_config_select,
    input wire ldio_pkg::ldio_cycle_t host_cycle,
    output logic cfg_claim,
    output logic [7:0] cfg_rdata,
    output ldio_pkg::ldio_decode_t dec_q,
    input wire ldio_pkg::ldio_irq_req_t func_irq,
    input wire logic par_ext_mode,
    output logic [15:1] irq_line_q,
    output logic sys_mgmt_irq_n
);
    // ------------------------------------------------------------
    // reset release and strap sync
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic strap_s1_q;
    logic strap_s2_q;
    logic rst_n;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= strap_config_select;
            strap_s2_q <= strap_s1_q;
        end
    end

    // ------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------
    logic [7:0] index_q;
    logic [3:0] ldn_q;
    logic [7:0] osc_q;
    logic [15:0] cfg_base_q;
    logic strap_taken_q;
    logic [15:0] act_q;
    logic [15:0] base_q [16];
    logic [15:0] base2_q [16];
    logic [3:0] irq_q [16];

    // ------------------------------------------------------------
    // configuration port access
    // ------------------------------------------------------------
    wire [15:0] a = host_cycle.addr;
    wire full16 = osc_q[ldio_pkg::OSC_FULL16_BIT];
    wire hi_ok = !full16 || (a[15:12] == 4'h0);
    wire [11:0] cfg_base12 = cfg_base_q[11:0] & ldio_pkg::MSK_2;
    wire cfg_hit = host_cycle.valid && hi_ok
        && ((a[11:0] & ldio_pkg::MSK_2) == cfg_base12);
    wire idx_wr = cfg_hit && host_cycle.write && !a[0];
    wire dat_wr = cfg_hit && host_cycle.write && a[0];
    wire [7:0] wd = host_cycle.wdata;
    wire sel_ldn = index_q == ldio_pkg::IDX_LDN;
    wire sel_osc = index_q == ldio_pkg::IDX_OSC;
    wire sel_cfg_lo = index_q == ldio_pkg::IDX_CFG_LO;
    wire sel_cfg_hi = index_q == ldio_pkg::IDX_CFG_HI;
    wire sel_act = index_q == ldio_pkg::IDX_ACT;
    wire sel_bhi = index_q == ldio_pkg::IDX_BASE_HI;
    wire sel_blo = index_q == ldio_pkg::IDX_BASE_LO;
    wire has_b2 = ldn_q == ldio_pkg::LD_SP2;
    wire sel_b2hi = has_b2 && index_q == ldio_pkg::IDX_BASE2_HI;
    wire sel_b2lo = has_b2 && index_q == ldio_pkg::IDX_BASE2_LO;
    wire sel_irq = index_q == ldio_pkg::IDX_IRQ;
    wire [15:0] ldn_valid = 16'h06B9;
    wire ld_ok = ldn_valid[ldn_q];
    wire has_base = ld_ok && ldn_q != ldio_pkg::LD_KBD;
    wire [15:0] strap_base =
        strap_s2_q ? ldio_pkg::CFG_PORT_STRAP1 : ldio_pkg::CFG_PORT_STRAP0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            index_q <= 8'h00;
            ldn_q <= 4'h0;
            osc_q <= ldio_pkg::OSC_RST;
            cfg_base_q <= ldio_pkg::CFG_PORT_STRAP0;
            strap_taken_q <= 1'b0;
        end else begin
            strap_taken_q <= 1'b1;
            if (!strap_taken_q) begin
                cfg_base_q <= strap_base;
            end else if (dat_wr && sel_cfg_lo) begin
                cfg_base_q[7:0] <= wd & ldio_pkg::MSK_2[7:0];
            end else if (dat_wr && sel_cfg_hi) begin
                cfg_base_q[15:8] <= wd;
            end
            if (idx_wr) begin
                index_q <= wd;
            end
            if (dat_wr && sel_ldn) begin
                ldn_q <= wd[3:0];
            end
            if (dat_wr && sel_osc) begin
                osc_q <= wd;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                base_q[i] <= 16'h0000;
                base2_q[i] <= 16'h0000;
                irq_q[i] <= (i == 0) ? ldio_pkg::IRQ_RST_FDC : ldio_pkg::IRQ_RST;
            end
        end else if (dat_wr && ld_ok) begin
            if (sel_act) begin
                act_q[ldn_q] <= wd[ldio_pkg::ACT_BIT];
            end
            if (sel_bhi && has_base) begin
                base_q[ldn_q][15:8] <= wd;
            end
            if (sel_blo && has_base) begin
                base_q[ldn_q][7:0] <= wd;
            end
            if (sel_b2hi) begin
                base2_q[ldn_q][15:8] <= wd;
            end
            if (sel_b2lo) begin
                base2_q[ldn_q][7:0] <= wd;
            end
            if (sel_irq) begin
                irq_q[ldn_q] <= wd[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [7:0] rd_idx = index_q;
    wire [7:0] rd_reg =
        sel_ldn ? {4'h0, ldn_q} :
        sel_osc ? osc_q :
        sel_cfg_lo ? cfg_base_q[7:0] :
        sel_cfg_hi ? cfg_base_q[15:8] :
        !ld_ok ? 8'h00 :
        sel_act ? {7'h00, act_q[ldn_q]} :
        (sel_bhi && has_base) ? base_q[ldn_q][15:8] :
        (sel_blo && has_base) ? base_q[ldn_q][7:0] :
        sel_b2hi ? base2_q[ldn_q][15:8] :
        sel_b2lo ? base2_q[ldn_q][7:0] :
        sel_irq ? {4'h0, irq_q[ldn_q]} : 8'h00;
    assign cfg_claim = cfg_hit;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_hit && !host_cycle.write) begin
            cfg_rdata <= a[0] ? rd_reg : rd_idx;
        end
    end

    // ------------------------------------------------------------
    // function address decode
    // ------------------------------------------------------------
    function automatic logic win(input logic [15:0] base, input logic [11:0] lo,
                                 input logic [11:0] hi, input logic [11:0] msk,
                                 input logic [11:0] addr);
        logic [11:0] b;
        b = base[11:0];
        win = (base[15:12] == 4'h0) && (b >= lo) && (b <= hi)
            && ((b & ~msk) == 12'h000)
            && ((addr & msk) == (b & msk));
    endfunction

    wire [11:0] a12 = a[11:0];
    wire go = host_cycle.valid && hi_ok && !cfg_hit;
    wire [15:0] pb = base_q[ldio_pkg::LD_PAR];
    wire [15:0] gb = base_q[ldio_pkg::LD_GAME];
    wire [15:0] mb = base_q[ldio_pkg::LD_PME];
    wire [15:0] ib = base2_q[ldio_pkg::LD_SP2];
    wire fdc_h = act_q[ldio_pkg::LD_FDC] && win(base_q[ldio_pkg::LD_FDC],
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI8, ldio_pkg::MSK_8, a12);
    wire sp1_h = act_q[ldio_pkg::LD_SP1] && win(base_q[ldio_pkg::LD_SP1],
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI8, ldio_pkg::MSK_8, a12);
    wire sp2_h = act_q[ldio_pkg::LD_SP2] && win(base_q[ldio_pkg::LD_SP2],
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI8, ldio_pkg::MSK_8, a12);
    wire ir_h = act_q[ldio_pkg::LD_SP2] && win(ib,
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI8, ldio_pkg::MSK_8, a12);
    wire par_ok = act_q[ldio_pkg::LD_PAR] && win(pb,
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI4, ldio_pkg::MSK_4, pb[11:0]);
    wire par_8al = pb[2] == 1'b0;
    wire par_h = par_ok && ((a12 & ldio_pkg::MSK_4) == (pb[11:0] & ldio_pkg::MSK_4))
        && !(par_8al && a12[1:0] == 2'h3);
    wire [11:0] ext_d = a12 - ((pb[11:0] & ldio_pkg::MSK_4) + ldio_pkg::PAR_EXT_OFS);
    wire ext_h = par_ok && (ext_d <= ldio_pkg::PAR_EXT_LAST);
    wire epp_h = par_ok && par_8al
        && ((a12 & ldio_pkg::MSK_8) == (pb[11:0] & ldio_pkg::MSK_8))
        && (a12[2:0] >= ldio_pkg::PAR_EPP_FIRST);
    wire kbd_h = act_q[ldio_pkg::LD_KBD]
        && (a12 == ldio_pkg::KBD_DATA_PORT || a12 == ldio_pkg::KBD_CMD_PORT);
    wire game_h = act_q[ldio_pkg::LD_GAME] && win(gb,
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI1, ldio_pkg::MSK_1, a12);
    wire pme_h = act_q[ldio_pkg::LD_PME] && win(mb,
        ldio_pkg::RNG_PME_LO, ldio_pkg::RNG_PME_HI, ldio_pkg::MSK_128, a12);
    wire [11:0] pme_ofs = a12 & ~ldio_pkg::MSK_128;

    wire [11:0] ofs =
        ext_h ? ext_d :
        pme_h ? pme_ofs :
        par_h ? {10'h000, a12[1:0]} :
        epp_h ? {9'h000, a12[2:0]} :
        kbd_h ? (a12 - ldio_pkg::KBD_DATA_PORT) :
        game_h ? 12'h000 : {9'h000, a12[2:0]};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dec_q <= '0;
        end else begin
            dec_q.fdc <= go && fdc_h;
            dec_q.par <= go && par_h;
            dec_q.par_ext <= go && ext_h;
            dec_q.par_epp <= go && epp_h;
            dec_q.sp1 <= go && sp1_h;
            dec_q.sp2 <= go && sp2_h;
            dec_q.infrared_engine_regs <= go && ir_h;
            dec_q.keyboard_ctrl <= go && kbd_h;
            dec_q.game <= go && game_h;
            dec_q.power_event_block <= go && pme_h;
            dec_q.pme_status <= go && pme_h && pme_ofs == ldio_pkg::PME_STATUS_OFS;
            dec_q.pme_scan <= go && pme_h && pme_ofs == ldio_pkg::PME_SCAN_OFS;
            dec_q.offset <= go ? ofs : 12'h000;
        end
    end

    // ------------------------------------------------------------
    // interrupt routing
    // ------------------------------------------------------------
    wire [15:0] route_ok;
    assign route_ok[ldio_pkg::LD_FDC] = win(base_q[ldio_pkg::LD_FDC],
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI8, ldio_pkg::MSK_8,
        base_q[ldio_pkg::LD_FDC][11:0]);
    assign route_ok[ldio_pkg::LD_SP1] = win(base_q[ldio_pkg::LD_SP1],
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI8, ldio_pkg::MSK_8,
        base_q[ldio_pkg::LD_SP1][11:0]);
    assign route_ok[ldio_pkg::LD_SP2] = win(base_q[ldio_pkg::LD_SP2],
        ldio_pkg::RNG_LO, ldio_pkg::RNG_HI8, ldio_pkg::MSK_8,
        base_q[ldio_pkg::LD_SP2][11:0]);
    assign route_ok[ldio_pkg::LD_PAR] = par_ok;
    assign route_ok[ldio_pkg::LD_KBD] = 1'b1;
    assign route_ok[ldio_pkg::LD_GAME] = win(gb, ldio_pkg::RNG_LO,
        ldio_pkg::RNG_HI1, ldio_pkg::MSK_1, gb[11:0]);
    assign route_ok[ldio_pkg::LD_PME] = win(mb, ldio_pkg::RNG_PME_LO,
        ldio_pkg::RNG_PME_HI, ldio_pkg::MSK_128, mb[11:0]);
    assign route_ok[2:1] = 2'b00;
    assign route_ok[6] = 1'b0;
    assign route_ok[8] = 1'b0;
    assign route_ok[15:11] = 5'h00;

    wire [15:0] req;
    assign req[ldio_pkg::LD_FDC] = func_irq.fdc;
    assign req[ldio_pkg::LD_PAR] = par_ext_mode ? !func_irq.par : func_irq.par;
    assign req[ldio_pkg::LD_SP1] = func_irq.sp1;
    assign req[ldio_pkg::LD_SP2] = func_irq.sp2;
    assign req[ldio_pkg::LD_KBD] = func_irq.keyboard_ctrl;
    assign req[ldio_pkg::LD_GAME] = func_irq.game;
    assign req[ldio_pkg::LD_PME] = func_irq.power_event_block;
    assign req[2:1] = 2'b00;
    assign req[6] = 1'b0;
    assign req[8] = 1'b0;
    assign req[15:11] = 5'h00;

    logic [15:0] lines;
    always_comb begin
        lines = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (act_q[i] && route_ok[i] && irq_q[i] != ldio_pkg::IRQ_NONE) begin
                lines[irq_q[i]] = lines[irq_q[i]] | req[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_line_q <= 15'h0000;
            sys_mgmt_irq_n <= 1'b1;
        end else begin
            irq_line_q <= lines[15:1];
            sys_mgmt_irq_n <= !lines[ldio_pkg::IRQ_SHARED_SMI];
        end
    end
endmodule

/* File: core/ldio_pkg.sv */
// constants and types for the logical device decode and interrupt select block
// Behaviour
// - floppy, serial bases 0x100-0xFF8, 8-aligned, eight ports
// - parallel base 4-aligned, extended regs at +400h-402h
// - enhanced parallel +3..+7 only on 8-aligned base
// - keyboard fixed at 60 and 64
// - game port single byte 0x100-0xFFF
// - power event block 128-aligned up to 0xF7F
// - second serial second base maps infrared registers
// - compare host address bits 11..0 with base
// - oscillator bit 6 demands upper bits zero
// - config port 0x2E or 0x4E by strap
// - index then data port, relocatable via 0x26/0x27
// - interrupt select bits 3..0 pick line
// - code 0 none, 1..15 lines, 2 shared
// - edges active high, parallel extended modes excepted
// - base high byte 0x60, low byte 0x61
// - out of range base ignores all accesses
// - decode only while activate bit 0 set
package ldio_pkg;
    // ------------------------------------------------------------
    // configuration register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_LDN = 8'h07;
    localparam logic [7:0] IDX_OSC = 8'h24;
    localparam logic [7:0] IDX_CFG_LO = 8'h26;
    localparam logic [7:0] IDX_CFG_HI = 8'h27;
    localparam logic [7:0] IDX_ACT = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_BASE2_HI = 8'h62;
    localparam logic [7:0] IDX_BASE2_LO = 8'h63;
    localparam logic [7:0] IDX_IRQ = 8'h70;
    localparam int OSC_FULL16_BIT = 6;
    localparam int ACT_BIT = 0;
    // ------------------------------------------------------------
    // logical device numbers
    // ------------------------------------------------------------
    localparam logic [3:0] LD_FDC = 4'h0;
    localparam logic [3:0] LD_PAR = 4'h3;
    localparam logic [3:0] LD_SP1 = 4'h4;
    localparam logic [3:0] LD_SP2 = 4'h5;
    localparam logic [3:0] LD_KBD = 4'h7;
    localparam logic [3:0] LD_GAME = 4'h9;
    localparam logic [3:0] LD_PME = 4'hA;
    // ------------------------------------------------------------
    // address ranges, alignment masks, fixed ports
    // ------------------------------------------------------------
    localparam logic [11:0] RNG_LO = 12'h100;
    localparam logic [11:0] RNG_HI8 = 12'hFF8;
    localparam logic [11:0] RNG_HI4 = 12'hFFC;
    localparam logic [11:0] RNG_HI1 = 12'hFFF;
    localparam logic [11:0] RNG_PME_LO = 12'h000;
    localparam logic [11:0] RNG_PME_HI = 12'hF7F;
    localparam logic [11:0] RNG_CFG_HI = 12'hFFE;
    localparam logic [11:0] MSK_8 = 12'hFF8;
    localparam logic [11:0] MSK_4 = 12'hFFC;
    localparam logic [11:0] MSK_2 = 12'hFFE;
    localparam logic [11:0] MSK_1 = 12'hFFF;
    localparam logic [11:0] MSK_128 = 12'hF80;
    localparam logic [11:0] PAR_EXT_OFS = 12'h400;
    localparam logic [11:0] PAR_EXT_LAST = 12'h002;
    localparam logic [2:0] PAR_EPP_FIRST = 3'h3;
    localparam logic [11:0] KBD_DATA_PORT = 12'h060;
    localparam logic [11:0] KBD_CMD_PORT = 12'h064;
    localparam logic [11:0] PME_STATUS_OFS = 12'h000;
    localparam logic [11:0] PME_SCAN_OFS = 12'h05F;
    localparam logic [15:0] CFG_PORT_STRAP0 = 16'h002E;
    localparam logic [15:0] CFG_PORT_STRAP1 = 16'h004E;
    // ------------------------------------------------------------
    // reset values and interrupt select codes
    // ------------------------------------------------------------
    localparam logic [3:0] IRQ_RST_FDC = 4'h6;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam logic [3:0] IRQ_NONE = 4'h0;
    localparam logic [3:0] IRQ_SHARED_SMI = 4'h2;
    localparam logic [7:0] OSC_RST = 8'h00;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ldio_cycle_t;

    typedef struct packed {
        logic fdc;
        logic par;
        logic par_ext;
        logic par_epp;
        logic sp1;
        logic sp2;
        logic infrared_engine_regs;
        logic keyboard_ctrl;
        logic game;
        logic power_event_block;
        logic pme_status;
        logic pme_scan;
        logic [11:0] offset;
    } ldio_decode_t;

    typedef struct packed {
        logic fdc;
        logic par;
        logic sp1;
        logic sp2;
        logic keyboard_ctrl;
        logic game;
        logic power_event_block;
    } ldio_irq_req_t;
endpackage

/* File: sim/ldio_top_asserts.sv */
// checker of decode and interrupt outputs of ldio_top
module ldio_top_asserts (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic strap_config_select,
    input wire ldio_pkg::ldio_cycle_t host_cycle,
    input wire logic cfg_claim,
    input wire logic [7:0] cfg_rdata,
    input wire ldio_pkg::ldio_decode_t dec_q,
    input wire ldio_pkg::ldio_irq_req_t func_irq,
    input wire logic par_ext_mode,
    input wire logic [15:1] irq_line_q,
    input wire logic sys_mgmt_irq_n
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_smi_mirrors_line2: assert property (sys_mgmt_irq_n == !irq_line_q[2])
        else $error("smi output not inverse of line 2");
    a_hit_needs_cycle: assert property (dec_q[23:12] != 12'h000 |-> $past(host_cycle.valid))
        else $error("decode hit without host cycle");
    a_idle_offset_zero: assert property (!$past(host_cycle.valid) |-> dec_q.offset == 12'h000)
        else $error("offset nonzero without cycle");
    a_kbd_fixed_ports: assert property (dec_q.keyboard_ctrl |->
        ($past(host_cycle.addr[11:0]) == 12'h060 && dec_q.offset == 12'h000) ||
        ($past(host_cycle.addr[11:0]) == 12'h064 && dec_q.offset == 12'h004))
        else $error("keyboard hit off its fixed ports");
    a_eight_port_offset: assert property (dec_q.fdc || dec_q.sp1 || dec_q.sp2 ||
        dec_q.infrared_engine_regs |-> dec_q.offset == {9'h000, $past(host_cycle.addr[2:0])})
        else $error("eight port offset wrong");
    a_par_ext_span: assert property (dec_q.par_ext |-> $past(host_cycle.addr[1:0]) != 2'h3 &&
        dec_q.offset == {10'h000, $past(host_cycle.addr[1:0])})
        else $error("extended parallel offset wrong");
    a_epp_upper_ports: assert property (dec_q.par_epp |-> $past(host_cycle.addr[2:0]) >= 3'h3)
        else $error("enhanced parallel hit below +3");
    a_game_single_byte: assert property (dec_q.game |-> dec_q.offset == 12'h000 &&
        $past(host_cycle.addr[11:8]) != 4'h0)
        else $error("game port hit wrong");
    a_pme_scan_offset: assert property (dec_q.pme_scan |-> dec_q.power_event_block &&
        dec_q.offset == 12'h05F && $past(host_cycle.addr[6:0]) == 7'h5F)
        else $error("scan code offset wrong");
    a_cfg_not_function: assert property (host_cycle.valid && cfg_claim |=> dec_q[23:12] == 12'h000)
        else $error("config port cycle hit a function");
    a_claim_needs_cycle: assert property (cfg_claim |-> host_cycle.valid)
        else $error("config claim without host cycle");
    a_irq_needs_request: assert property (irq_line_q != 15'h0000 |->
        $past(func_irq) != '0 || $past(par_ext_mode))
        else $error("interrupt line without request");
endmodule
bind ldio_top ldio_top_asserts u_chk (.mclk(mclk), .reset_n(reset_n),
    .strap_config_select(strap_config_select), .host_cycle(host_cycle), .cfg_claim(cfg_claim),
    .cfg_rdata(cfg_rdata), .dec_q(dec_q), .func_irq(func_irq), .par_ext_mode(par_ext_mode),
    .irq_line_q(irq_line_q), .sys_mgmt_irq_n(sys_mgmt_irq_n));

/* File: sim/ldio_host.sv */
// host bus controller model issuing i/o cycles
module ldio_host (
    input wire logic mclk,
    output ldio_pkg::ldio_cycle_t host_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // cycle tasks
    // ------------------------------------------------------------
    initial host_cycle = '0;
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        host_cycle <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge mclk);
        // released bus shows no stale value
        host_cycle <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask
    task automatic cfg_wr(input logic [15:0] port, input logic [7:0] idx, input logic [7:0] d);
        io(1'b1, port, idx);
        io(1'b1, port + 16'h0001, d);
    endtask
    task automatic cfg_rd(input logic [15:0] port, input logic [7:0] idx);
        io(1'b1, port, idx);
        io(1'b0, port + 16'h0001, 8'h00);
    endtask
endmodule

/* File: sim/tb_logical_device_io_decode_irq_select.sv */
// self-checking bench of the decode and interrupt select block
module tb_logical_device_io_decode_irq_select;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] F_FDC = 12'h800, F_PAR = 12'h400, F_EXT = 12'h200, F_EPP = 12'h100;
    localparam logic [11:0] F_SP1 = 12'h080, F_IR = 12'h020, F_KBD = 12'h010, F_GAME = 12'h008;
    localparam logic [11:0] F_PME = 12'h004, F_PST = 12'h002, F_PSC = 12'h001;
    logic mclk, reset_n, strap_config_select, par_ext_mode, cfg_claim, sys_mgmt_irq_n;
    logic [7:0] cfg_rdata;
    logic [15:1] irq_line_q;
    logic [15:0] cfg_port, lfsr;
    ldio_pkg::ldio_cycle_t host_cycle;
    ldio_pkg::ldio_decode_t dec_q;
    ldio_pkg::ldio_irq_req_t func_irq;
    int n_mismatch, checks, cycles;
    logic [7:0] model_reg [int];
    // ------------------------------------------------------------
    // instances, clock, helpers
    // ------------------------------------------------------------
    ldio_top uut (.mclk(mclk), .reset_n(reset_n), .strap_config_select(strap_config_select),
        .host_cycle(host_cycle), .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata), .dec_q(dec_q),
        .func_irq(func_irq), .par_ext_mode(par_ext_mode), .irq_line_q(irq_line_q),
        .sys_mgmt_irq_n(sys_mgmt_irq_n));
    ldio_host host (.mclk(mclk), .host_cycle(host_cycle));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 6000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (exp !== got) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] rnd8();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task automatic do_reset(input logic strap);
        @(posedge mclk);
        reset_n <= 1'b0;
        strap_config_select <= strap;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        cfg_port = strap ? 16'h004E : 16'h002E;
        model_reg.delete();
    endtask
    task automatic wr(input logic [3:0] ld, input logic [7:0] idx, input logic [7:0] d);
        host.cfg_wr(cfg_port, ldio_pkg::IDX_LDN, {4'h0, ld});
        host.cfg_wr(cfg_port, idx, d);
        if (idx inside {8'h30, 8'h60, 8'h61, 8'h70} || (ld == 4'h5 && idx inside {8'h62, 8'h63}))
            model_reg[{ld, idx}] = d;
    endtask
    task automatic rd_chk(input logic [3:0] ld, input logic [7:0] idx);
        logic [7:0] exp;
        exp = (ld == 4'h0 && idx == ldio_pkg::IDX_IRQ) ? 8'h06 : 8'h00;
        if (model_reg.exists({ld, idx})) exp = model_reg[{ld, idx}];
        host.cfg_wr(cfg_port, ldio_pkg::IDX_LDN, {4'h0, ld});
        host.cfg_rd(cfg_port, idx);
        #1 check("cfg_rdata", {16'h0000, exp}, {16'h0000, cfg_rdata});
    endtask
    task automatic setup(input logic [3:0] ld, input logic [15:0] base, input logic [7:0] act);
        wr(ld, ldio_pkg::IDX_BASE_HI, base[15:8]);
        wr(ld, ldio_pkg::IDX_BASE_LO, base[7:0]);
        wr(ld, ldio_pkg::IDX_ACT, act);
    endtask
    task automatic probe(input logic [15:0] a, input logic [11:0] flags, input logic [11:0] ofs);
        host.io(1'b0, a, 8'h00);
        #1 check("dec_q", {flags, ofs}, dec_q);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0] k;
        reset_n = 1'b0;
        strap_config_select = 1'b0;
        par_ext_mode = 1'b0;
        func_irq = '0;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        lfsr = 16'h004D;
        do_reset(1'b0);
        rd_chk(4'h0, ldio_pkg::IDX_IRQ);
        wr(4'h4, 8'h40, rnd8());
        rd_chk(4'h4, 8'h40);
        setup(4'h4, 16'h03F8, 8'h00);
        probe(16'h03FD, 12'h000, 12'h005);
        wr(4'h4, ldio_pkg::IDX_ACT, 8'h01);
        rd_chk(4'h4, ldio_pkg::IDX_BASE_LO);
        repeat (4) begin
            k = 3'(rnd8());
            probe(16'h03F8 + {13'h0000, k}, F_SP1, {9'h000, k});
        end
        probe(16'h0400, 12'h000, 12'h000);
        probe(16'h13F8, F_SP1, 12'h000);
        wr(4'h0, ldio_pkg::IDX_OSC, 8'h40);
        probe(16'h13F8, 12'h000, 12'h000);
        probe(16'h03F8, F_SP1, 12'h000);
        wr(4'h0, ldio_pkg::IDX_OSC, 8'h00);
        setup(4'h4, 16'h03FC, 8'h01);
        probe(16'h03FC, 12'h000, 12'h004);
        setup(4'h4, 16'h00F8, 8'h01);
        probe(16'h00F8, 12'h000, 12'h000);
        setup(4'h0, 16'h03F0, 8'h01);
        probe(16'h03F7, F_FDC, 12'h007);
        wr(4'h7, ldio_pkg::IDX_ACT, 8'h01);
        probe(16'h0060, F_KBD, 12'h000);
        probe(16'h0064, F_KBD, 12'h004);
        probe(16'h0061, 12'h000, 12'h001);
        setup(4'h3, 16'h037C, 8'h01);
        probe(16'h037E, F_PAR, 12'h002);
        probe(16'h077C, F_EXT, 12'h000);
        probe(16'h077E, F_EXT, 12'h002);
        probe(16'h077F, 12'h000, 12'h007);
        setup(4'h3, 16'h0378, 8'h01);
        probe(16'h037B, F_EPP, 12'h003);
        probe(16'h037F, F_EPP, 12'h007);
        setup(4'h9, 16'h0201, 8'h01);
        probe(16'h0201, F_GAME, 12'h000);
        probe(16'h0202, 12'h000, 12'h002);
        setup(4'hA, 16'h0080, 8'h01);
        probe(16'h0080, F_PME | F_PST, 12'h000);
        probe(16'h00DF, F_PME | F_PSC, 12'h05F);
        wr(4'h5, ldio_pkg::IDX_BASE2_HI, 8'h02);
        wr(4'h5, ldio_pkg::IDX_BASE2_LO, 8'hE8);
        wr(4'h5, ldio_pkg::IDX_ACT, 8'h01);
        rd_chk(4'h5, ldio_pkg::IDX_BASE2_LO);
        probe(16'h02EA, F_IR, 12'h002);
        setup(4'h4, 16'h03F8, 8'h01);
        @(posedge mclk);
        func_irq.sp1 <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            wr(4'h4, ldio_pkg::IDX_IRQ, 8'(c));
            repeat (2) @(posedge mclk);
            #1 check("irq_line_q", 24'(c == 0 ? 0 : 1 << (c - 1)), 24'(irq_line_q));
            check("sys_mgmt_irq_n", 24'(c != 2), 24'(sys_mgmt_irq_n));
        end
        rd_chk(4'h4, ldio_pkg::IDX_IRQ);
        wr(4'h4, ldio_pkg::IDX_IRQ, 8'h00);
        wr(4'h3, ldio_pkg::IDX_IRQ, 8'h05);
        func_irq.sp1 <= 1'b0;
        par_ext_mode <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 check("irq_line_q", 24'h000010, 24'(irq_line_q));
        wr(4'h0, ldio_pkg::IDX_CFG_LO, 8'h71);
        cfg_port = 16'h0070;
        wr(4'h0, ldio_pkg::IDX_CFG_HI, 8'h03);
        cfg_port = 16'h0370;
        rd_chk(4'h3, ldio_pkg::IDX_IRQ);
        do_reset(1'b1);
        rd_chk(4'h0, ldio_pkg::IDX_IRQ);
        stop_test();
    end
endmodule
